// ### inc/ipa_map.svh
// constants of the pointer register unit: widths, steps, defaults
`ifndef IPA_MAP_SVH
`define IPA_MAP_SVH
`define IPA_PTR_COUNT 16
`define IPA_IDX_W 4
`define IPA_PTR_W 32
`define IPA_WORD_W 16
`define IPA_TASK_W 2
`define IPA_STEP_ONE 32'h00000001
`define IPA_STEP_TWO 32'h00000002
`define IPA_SHARE_DEFAULT 1'b0
`define IPA_PV_BASE 32'h00008000
`define IPA_CONV_DELTA 32'h00010000
`define IPA_MIN_PTR 4'h0
`endif

// ### inc/ipa_pkg.sv
// types of the pointer register unit: operation and addressing mode codes
package ipa_pkg;
	typedef enum logic [17:0] {
		IPA_OP_NONE = 18'h00001,
		IPA_OP_ADDR_LOAD = 18'h00002,
		IPA_OP_PV_ADDR_LOAD = 18'h00004,
		IPA_OP_DBL_TRANSFER = 18'h00008,
		IPA_OP_DBL_SWAP = 18'h00010,
		IPA_OP_DBL_COMPARE = 18'h00020,
		IPA_OP_DBL_INC = 18'h00040,
		IPA_OP_DBL_DEC = 18'h00080,
		IPA_OP_DBL_ADD = 18'h00100,
		IPA_OP_DBL_SUB = 18'h00200,
		IPA_OP_ADDR_IMPORT = 18'h00400,
		IPA_OP_ADDR_EXPORT = 18'h00800,
		IPA_OP_RECORD_LOCATE = 18'h01000,
		IPA_OP_RECORD_NUMBER = 18'h02000,
		IPA_OP_INDIRECT = 18'h04000,
		IPA_OP_WORD_TRANSFER = 18'h08000,
		IPA_OP_RANGE_MIN = 18'h10000,
		IPA_OP_OFFSET_LOAD = 18'h20000
	} ipa_op_t;

	typedef enum logic [6:0] {
		IPA_AM_PLAIN = 7'h01,
		IPA_AM_CONST = 7'h02,
		IPA_AM_DROFF = 7'h04,
		IPA_AM_INC1 = 7'h08,
		IPA_AM_INC2 = 7'h10,
		IPA_AM_DEC1 = 7'h20,
		IPA_AM_DEC2 = 7'h40
	} ipa_mode_t;

	// ops allowed to name a pointer register as a direct operand
	function automatic logic ipa_direct_ok(input ipa_op_t op);
		case (op)
			IPA_OP_ADDR_LOAD, IPA_OP_PV_ADDR_LOAD, IPA_OP_DBL_TRANSFER,
			IPA_OP_DBL_SWAP, IPA_OP_DBL_COMPARE, IPA_OP_DBL_INC,
			IPA_OP_DBL_DEC, IPA_OP_DBL_ADD, IPA_OP_DBL_SUB,
			IPA_OP_ADDR_IMPORT, IPA_OP_ADDR_EXPORT, IPA_OP_RECORD_LOCATE,
			IPA_OP_RECORD_NUMBER: ipa_direct_ok = 1'b1;
			default: ipa_direct_ok = 1'b0;
		endcase
	endfunction
endpackage

// ### core/ipa_regfile.sv
// pointer and offset register storage, one bank per task or one shared bank
`timescale 1ns/1ns
`include "ipa_map.svh"
module ipa_regfile #(
	parameter int TASK_W = `IPA_TASK_W
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [TASK_W-1:0] bank_in,
	input wire logic [`IPA_IDX_W-1:0] rd_a_idx_in,
	input wire logic [`IPA_IDX_W-1:0] rd_b_idx_in,
	input wire logic [`IPA_IDX_W-1:0] rd_off_idx_in,
	output logic [`IPA_PTR_W-1:0] rd_a_out,
	output logic [`IPA_PTR_W-1:0] rd_b_out,
	output logic [`IPA_WORD_W-1:0] rd_off_out,
	input wire logic wr_a_en_in,
	input wire logic [`IPA_IDX_W-1:0] wr_a_idx_in,
	input wire logic [`IPA_PTR_W-1:0] wr_a_data_in,
	input wire logic wr_b_en_in,
	input wire logic [`IPA_IDX_W-1:0] wr_b_idx_in,
	input wire logic [`IPA_PTR_W-1:0] wr_b_data_in,
	input wire logic off_wr_en_in,
	input wire logic [`IPA_IDX_W-1:0] off_wr_idx_in,
	input wire logic [`IPA_WORD_W-1:0] off_wr_data_in
);
	localparam int DEPTH = (1 << TASK_W) * `IPA_PTR_COUNT;

	// one 32-bit word per pointer, lower and upper halves together
	logic [`IPA_PTR_W-1:0] ptr_mem [0:DEPTH-1];
	logic [`IPA_WORD_W-1:0] off_mem [0:DEPTH-1];

	// bank-relative reads
	assign rd_a_out = ptr_mem[{bank_in, rd_a_idx_in}];
	assign rd_b_out = ptr_mem[{bank_in, rd_b_idx_in}];
	assign rd_off_out = off_mem[{bank_in, rd_off_idx_in}];

	// port a written last so it wins if a swap names one register twice
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				ptr_mem[i] <= '0;
			end
		end else begin
			if (wr_b_en_in) begin
				ptr_mem[{bank_in, wr_b_idx_in}] <= wr_b_data_in;
			end
			if (wr_a_en_in) begin
				ptr_mem[{bank_in, wr_a_idx_in}] <= wr_a_data_in;
			end
		end
	end

	// offset registers
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				off_mem[i] <= '0;
			end
		end else if (off_wr_en_in) begin
			off_mem[{bank_in, off_wr_idx_in}] <= off_wr_data_in;
		end
	end
endmodule

// ### core/ipa_addr_gen.sv
// effective address and pointer update for one indirect operand
`timescale 1ns/1ns
`include "ipa_map.svh"
module ipa_addr_gen (
	input wire logic [`IPA_PTR_W-1:0] ptr_in,
	input wire ipa_pkg::ipa_mode_t mode_in,
	input wire logic [`IPA_WORD_W-1:0] const_off_in,
	input wire logic [`IPA_WORD_W-1:0] dr_off_in,
	output logic [`IPA_PTR_W-1:0] ea_out,
	output logic [`IPA_PTR_W-1:0] next_ptr_out,
	output logic upd_out
);
	import ipa_pkg::*;

	logic [`IPA_PTR_W-1:0] const_ext;
	logic [`IPA_PTR_W-1:0] dr_ext;

	// both offsets are signed words
	assign const_ext = {{16{const_off_in[15]}}, const_off_in};
	assign dr_ext = {{16{dr_off_in[15]}}, dr_off_in};

	// sums are 32 bits wide so they wrap by themselves
	always_comb begin
		ea_out = ptr_in;
		next_ptr_out = ptr_in;
		upd_out = 1'b0;
		case (mode_in)
			IPA_AM_PLAIN: ea_out = ptr_in;
			IPA_AM_CONST: ea_out = ptr_in + const_ext;
			IPA_AM_DROFF: ea_out = ptr_in + dr_ext;
			IPA_AM_INC1, IPA_AM_INC2: begin
				ea_out = ptr_in;
				next_ptr_out = ptr_in + ((mode_in == IPA_AM_INC1) ?
					`IPA_STEP_ONE : `IPA_STEP_TWO);
				upd_out = 1'b1;
			end
			IPA_AM_DEC1, IPA_AM_DEC2: begin
				next_ptr_out = ptr_in - ((mode_in == IPA_AM_DEC1) ?
					`IPA_STEP_ONE : `IPA_STEP_TWO);
				ea_out = next_ptr_out;
				upd_out = 1'b1;
			end
			default: ea_out = ptr_in;
		endcase
	end
endmodule

// ### core/ipa_core.sv
// pointer register unit: operation decode, flags, results and checks
`timescale 1ns/1ns
`include "ipa_map.svh"
module ipa_core #(
	parameter int TASK_W = `IPA_TASK_W,
	parameter logic [`IPA_PTR_W-1:0] PV_BASE = `IPA_PV_BASE,
	parameter logic [`IPA_PTR_W-1:0] CONV_DELTA = `IPA_CONV_DELTA
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic share_mode_in,
	input wire logic [TASK_W-1:0] task_in,
	input wire logic op_valid_in,
	input wire ipa_pkg::ipa_op_t op_in,
	input wire logic direct_ptr_in,
	input wire logic [`IPA_IDX_W-1:0] ptr_sel_in,
	input wire logic [`IPA_IDX_W-1:0] ptr_sel2_in,
	input wire logic [`IPA_IDX_W-1:0] off_sel_in,
	input wire ipa_pkg::ipa_mode_t mode_in,
	input wire logic [`IPA_WORD_W-1:0] const_off_in,
	input wire logic [`IPA_PTR_W-1:0] operand_in,
	input wire logic [`IPA_WORD_W-1:0] word_src_in,
	input wire logic range_first_in,
	output logic register_sharing_status_bit_out,
	output logic done_out,
	output logic err_out,
	output logic [`IPA_PTR_W-1:0] ea_out,
	output logic [`IPA_PTR_W-1:0] data_out,
	output logic eq_flag_out,
	output logic lt_flag_out,
	output logic gt_flag_out
);
	import ipa_pkg::*;

	logic shared;
	logic strap_taken;
	logic [TASK_W-1:0] bank;
	logic illegal;
	logic take;
	logic [`IPA_PTR_W-1:0] ptr_a;
	logic [`IPA_PTR_W-1:0] ptr_b;
	logic [`IPA_WORD_W-1:0] off_rd;
	logic [`IPA_PTR_W-1:0] gen_ea;
	logic [`IPA_PTR_W-1:0] gen_next;
	logic gen_upd;
	logic wr_a_en;
	logic [`IPA_IDX_W-1:0] wr_a_idx;
	logic [`IPA_PTR_W-1:0] wr_a_data;
	logic wr_b_en;
	logic off_wr_en;
	logic [`IPA_WORD_W-1:0] run_min;
	logic min_better;
	logic [`IPA_WORD_W-1:0] next_min;
	logic [`IPA_PTR_W-1:0] next_data;

	// strap caught on the first edge after release, never under reset
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			shared <= `IPA_SHARE_DEFAULT;
			strap_taken <= 1'b0;
		end else if (!strap_taken) begin
			shared <= share_mode_in;
			strap_taken <= 1'b1;
		end
	end

	// read-only view of the sharing choice
	assign register_sharing_status_bit_out = shared;

	// shared mode folds every task onto bank zero
	assign bank = shared ? '0 : task_in;

	// non-listed ops may only reach pointers indirectly
	assign illegal = op_valid_in && direct_ptr_in && !ipa_direct_ok(op_in);
	assign take = op_valid_in && !illegal;

	ipa_regfile #(
		.TASK_W(TASK_W)
	) u_regs (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.bank_in(bank),
		.rd_a_idx_in(ptr_sel_in),
		.rd_b_idx_in(ptr_sel2_in),
		.rd_off_idx_in(off_sel_in),
		.rd_a_out(ptr_a),
		.rd_b_out(ptr_b),
		.rd_off_out(off_rd),
		.wr_a_en_in(wr_a_en),
		.wr_a_idx_in(wr_a_idx),
		.wr_a_data_in(wr_a_data),
		.wr_b_en_in(wr_b_en),
		.wr_b_idx_in(ptr_sel2_in),
		.wr_b_data_in(ptr_a),
		.off_wr_en_in(off_wr_en),
		.off_wr_idx_in(off_sel_in),
		.off_wr_data_in(word_src_in)
	);

	ipa_addr_gen u_gen (
		.ptr_in(ptr_a),
		.mode_in(mode_in),
		.const_off_in(const_off_in),
		.dr_off_in(off_rd),
		.ea_out(gen_ea),
		.next_ptr_out(gen_next),
		.upd_out(gen_upd)
	);

	// running minimum; a fresh run always takes its first word
	assign min_better = range_first_in || (word_src_in < run_min);
	assign next_min = min_better ? word_src_in : run_min;

	// pointer writes and result value for every operation
	always_comb begin
		wr_a_en = 1'b0;
		wr_a_idx = ptr_sel_in;
		wr_a_data = ptr_a;
		wr_b_en = 1'b0;
		off_wr_en = 1'b0;
		next_data = ptr_a;
		case (op_in)
			IPA_OP_ADDR_LOAD: begin
				wr_a_en = take;
				wr_a_data = operand_in;
			end
			IPA_OP_PV_ADDR_LOAD: begin
				wr_a_en = take;
				wr_a_data = PV_BASE + {16'h0000, operand_in[15:0]};
			end
			IPA_OP_DBL_TRANSFER: begin
				wr_a_en = take;
				wr_a_data = ptr_b;
			end
			IPA_OP_DBL_SWAP: begin
				wr_a_en = take;
				wr_b_en = take;
				wr_a_data = ptr_b;
			end
			IPA_OP_DBL_INC: begin
				wr_a_en = take;
				wr_a_data = ptr_a + `IPA_STEP_ONE;
			end
			IPA_OP_DBL_DEC: begin
				wr_a_en = take;
				wr_a_data = ptr_a - `IPA_STEP_ONE;
			end
			IPA_OP_DBL_ADD: begin
				wr_a_en = take;
				wr_a_data = ptr_a + operand_in;
			end
			IPA_OP_DBL_SUB: begin
				wr_a_en = take;
				wr_a_data = ptr_a - operand_in;
			end
			IPA_OP_ADDR_IMPORT: begin
				wr_a_en = take;
				wr_a_data = operand_in + CONV_DELTA;
			end
			IPA_OP_ADDR_EXPORT: wr_a_data = ptr_a - CONV_DELTA;
			IPA_OP_RECORD_LOCATE: begin
				wr_a_en = take;
				wr_a_data = operand_in;
			end
			IPA_OP_INDIRECT: begin
				wr_a_en = take && gen_upd;
				wr_a_data = gen_next;
			end
			IPA_OP_OFFSET_LOAD: off_wr_en = take;
			IPA_OP_RANGE_MIN: begin
				// address of the smallest word lands in pointer zero
				wr_a_en = take && min_better;
				wr_a_idx = `IPA_MIN_PTR;
				wr_a_data = operand_in;
			end
			default: wr_a_en = 1'b0;
		endcase
		case (op_in)
			IPA_OP_DBL_COMPARE, IPA_OP_RECORD_NUMBER: next_data = ptr_a;
			IPA_OP_WORD_TRANSFER: next_data = {16'h0000, word_src_in};
			IPA_OP_OFFSET_LOAD: next_data = {16'h0000, word_src_in};
			IPA_OP_RANGE_MIN: next_data = {16'h0000, next_min};
			default: next_data = wr_a_data;
		endcase
	end

	// running minimum store
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			run_min <= '0;
		end else if (take && op_in == IPA_OP_RANGE_MIN) begin
			run_min <= next_min;
		end
	end

	// completion pulse and refusal pulse, one cycle after the request
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			done_out <= 1'b0;
			err_out <= 1'b0;
		end else begin
			done_out <= take;
			err_out <= illegal;
		end
	end

	// result word and effective address
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			data_out <= '0;
			ea_out <= '0;
		end else if (take) begin
			data_out <= next_data;
			if (op_in == IPA_OP_INDIRECT) begin
				ea_out <= gen_ea;
			end
		end
	end

	// condition flags; other ops leave them as they were
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			eq_flag_out <= 1'b0;
			lt_flag_out <= 1'b0;
			gt_flag_out <= 1'b0;
		end else if (take) begin
			case (op_in)
				IPA_OP_DBL_COMPARE: begin
					eq_flag_out <= (ptr_a == ptr_b);
					lt_flag_out <= (ptr_a < ptr_b);
					gt_flag_out <= (ptr_a > ptr_b);
				end
				IPA_OP_WORD_TRANSFER: begin
					eq_flag_out <= (word_src_in == 16'h0000);
					lt_flag_out <= 1'b0;
					gt_flag_out <= 1'b0;
				end
				IPA_OP_RANGE_MIN: begin
					eq_flag_out <= (next_min == 16'h0000);
					lt_flag_out <= 1'b0;
					gt_flag_out <= 1'b0;
				end
				default: eq_flag_out <= eq_flag_out;
			endcase
		end
	end

	// checks on the design's own outputs
	a_strap_stable: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		strap_taken |=> $stable(register_sharing_status_bit_out))
		else $error("sharing status changed after capture");

	a_word_zero_eq: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		take && op_in == IPA_OP_WORD_TRANSFER |=>
		eq_flag_out == (data_out[15:0] == 16'h0000) && data_out == {16'h0000, $past(word_src_in)})
		else $error("word transfer equals flag wrong");

	a_min_zero_eq: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		take && op_in == IPA_OP_RANGE_MIN && range_first_in |=>
		eq_flag_out == ($past(word_src_in) == 16'h0000))
		else $error("range minimum equals flag wrong");

	a_refuse_direct: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		illegal |-> !wr_a_en && !wr_b_en ##1 err_out && !done_out)
		else $error("direct pointer use not refused");

	a_const_offset: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		take && op_in == IPA_OP_INDIRECT && mode_in == IPA_AM_CONST |->
		!wr_a_en ##1 ea_out == $past(ptr_a) + {{16{$past(const_off_in[15])}}, $past(const_off_in)})
		else $error("constant offset address wrong");

	a_dr_offset: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		take && op_in == IPA_OP_INDIRECT && mode_in == IPA_AM_DROFF |=>
		ea_out == $past(ptr_a) + {{16{$past(off_rd[15])}}, $past(off_rd)})
		else $error("offset register address wrong");

	a_post_inc: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		take && op_in == IPA_OP_INDIRECT && (mode_in == IPA_AM_INC1 || mode_in == IPA_AM_INC2)
		|=> ea_out == $past(ptr_a) && data_out == $past(ptr_a) +
		(($past(mode_in) == IPA_AM_INC1) ? `IPA_STEP_ONE : `IPA_STEP_TWO))
		else $error("post increment wrong");

	a_pre_dec: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		take && op_in == IPA_OP_INDIRECT && (mode_in == IPA_AM_DEC1 || mode_in == IPA_AM_DEC2)
		|=> ea_out == data_out && ea_out == $past(ptr_a) -
		(($past(mode_in) == IPA_AM_DEC1) ? `IPA_STEP_ONE : `IPA_STEP_TWO))
		else $error("pre decrement wrong");

	a_inc_wraps: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		take && op_in == IPA_OP_DBL_INC && ptr_a == 32'hffffffff |=> data_out == 32'h00000000)
		else $error("double increment does not wrap");

	a_swap_pair: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		take && op_in == IPA_OP_DBL_SWAP && ptr_sel_in != ptr_sel2_in |=>
		data_out == $past(ptr_b) && done_out)
		else $error("double swap result wrong");

	a_pv_load: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		take && op_in == IPA_OP_PV_ADDR_LOAD |=>
		data_out == PV_BASE + {16'h0000, $past(operand_in[15:0])})
		else $error("present value address wrong");

	a_export_conv: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		take && op_in == IPA_OP_ADDR_EXPORT |=> data_out + CONV_DELTA == $past(ptr_a))
		else $error("address export wrong");

	c_swap: cover property (@(posedge clk_in) disable iff (sys_rst_in)
		take && op_in == IPA_OP_DBL_SWAP);
	c_min_zero: cover property (@(posedge clk_in) disable iff (sys_rst_in)
		take && op_in == IPA_OP_RANGE_MIN ##1 eq_flag_out);
	c_shared: cover property (@(posedge clk_in) disable iff (sys_rst_in)
		strap_taken && register_sharing_status_bit_out);
	c_refused: cover property (@(posedge clk_in) disable iff (sys_rst_in) illegal);
endmodule

// ### tb/tb.sv
// self-checking bench of the pointer register unit, with a reference model
`timescale 1ns/1ns
`include "ipa_map.svh"
module tb;
	import ipa_pkg::*;
	logic clk_in, sys_rst_in, share_mode_in, op_valid_in, direct_ptr_in, range_first_in;
	logic [1:0] task_in;
	ipa_op_t op_in;
	ipa_mode_t mode_in;
	logic [3:0] ptr_sel_in, ptr_sel2_in, off_sel_in;
	logic [15:0] const_off_in, word_src_in;
	logic [31:0] operand_in, ea_out, data_out;
	logic register_sharing_status_bit_out, done_out, err_out;
	logic eq_flag_out, lt_flag_out, gt_flag_out;
	int errors, total_checks, cycles;
	// reference state: one bank per task, bank 0 when shared
	logic [31:0] ptr [4][16];
	logic [15:0] off [4][16];
	logic [31:0] x_data, x_ea, run_min;
	logic x_eq, x_lt, x_gt, x_share;
	ipa_op_t ops [18] = '{IPA_OP_NONE, IPA_OP_ADDR_LOAD, IPA_OP_PV_ADDR_LOAD,
		IPA_OP_DBL_TRANSFER, IPA_OP_DBL_SWAP, IPA_OP_DBL_COMPARE, IPA_OP_DBL_INC,
		IPA_OP_DBL_DEC, IPA_OP_DBL_ADD, IPA_OP_DBL_SUB, IPA_OP_ADDR_IMPORT,
		IPA_OP_ADDR_EXPORT, IPA_OP_RECORD_LOCATE, IPA_OP_RECORD_NUMBER, IPA_OP_INDIRECT,
		IPA_OP_WORD_TRANSFER, IPA_OP_RANGE_MIN, IPA_OP_OFFSET_LOAD};
	ipa_mode_t modes [7] = '{IPA_AM_PLAIN, IPA_AM_CONST, IPA_AM_DROFF, IPA_AM_INC1,
		IPA_AM_INC2, IPA_AM_DEC1, IPA_AM_DEC2};

	ipa_core dut (.clk_in, .sys_rst_in, .share_mode_in, .task_in, .op_valid_in, .op_in,
		.direct_ptr_in, .ptr_sel_in, .ptr_sel2_in, .off_sel_in, .mode_in, .const_off_in,
		.operand_in, .word_src_in, .range_first_in, .register_sharing_status_bit_out,
		.done_out, .err_out, .ea_out, .data_out, .eq_flag_out, .lt_flag_out, .gt_flag_out);

	// free-running clock, 8 ns
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end

	// hang guard: the whole run needs well under 5000 cycles
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors++;
			stop_test();
		end
	end

	task automatic stop_test();
		if (errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// ops that may name a pointer directly
	function automatic logic dir_ok(input ipa_op_t op);
		return !(op inside {IPA_OP_NONE, IPA_OP_INDIRECT, IPA_OP_WORD_TRANSFER,
			IPA_OP_RANGE_MIN, IPA_OP_OFFSET_LOAD});
	endfunction

	function automatic logic [31:0] sext(input logic [15:0] v);
		return {{16{v[15]}}, v};
	endfunction

	// reset with a given strap, then clear the model
	task automatic rst(input logic s);
		op_valid_in = 1'b0;
		sys_rst_in = 1'b1;
		share_mode_in = s;
		repeat (16) @(negedge clk_in);
		sys_rst_in = 1'b0;
		repeat (2) @(negedge clk_in);
		foreach (ptr[i, j]) ptr[i][j] = 32'h0;
		foreach (off[i, j]) off[i][j] = 16'h0;
		// the running minimum restarts from zero, as the design's store does
		{x_data, x_ea, x_eq, x_lt, x_gt, run_min} = '0;
		x_share = s;
		check(data_out, 32'h0);
		check({31'h0, register_sharing_status_bit_out}, {31'h0, s});
	endtask

	// one request at a falling edge; outputs looked at one cycle later
	task automatic do_op(input ipa_op_t op, input logic dir, input logic [3:0] a,
		input logic [3:0] b = 4'h0, input logic [31:0] opd = 32'h0, input logic [1:0] tk = 2'h0,
		input ipa_mode_t md = IPA_AM_PLAIN, input logic [15:0] c = 16'h0,
		input logic [15:0] w = 16'h0, input logic [3:0] o = 4'h0, input logic first = 1'b0);
		logic [1:0] bk;
		logic [31:0] va, vb, st;
		logic ok;
		bk = x_share ? 2'h0 : tk;
		va = ptr[bk][a];
		vb = ptr[bk][b];
		ok = !(dir && !dir_ok(op));
		st = (md == IPA_AM_INC2 || md == IPA_AM_DEC2) ? `IPA_STEP_TWO : `IPA_STEP_ONE;
		op_valid_in = 1'b1;
		op_in = op;
		mode_in = md;
		{direct_ptr_in, task_in} = {dir, tk};
		{ptr_sel_in, ptr_sel2_in, off_sel_in, operand_in} = {a, b, o, opd};
		{const_off_in, word_src_in, range_first_in} = {c, w, first};
		// model; a refused op leaves every state alone
		if (ok) begin
			case (op)
				IPA_OP_ADDR_LOAD: begin
					ptr[bk][a] = opd;
					x_data = opd;
				end
				IPA_OP_RECORD_LOCATE: begin
					ptr[bk][a] = opd;
					x_data = opd;
				end
				IPA_OP_PV_ADDR_LOAD: begin
					ptr[bk][a] = `IPA_PV_BASE + {16'h0, opd[15:0]};
					x_data = ptr[bk][a];
				end
				IPA_OP_DBL_TRANSFER: begin
					ptr[bk][a] = vb;
					x_data = vb;
				end
				IPA_OP_DBL_SWAP: begin
					ptr[bk][b] = va;
					ptr[bk][a] = vb;
					x_data = vb;
				end
				IPA_OP_DBL_COMPARE: begin
					{x_eq, x_lt, x_gt} = {va == vb, va < vb, va > vb};
					x_data = va;
				end
				// pointer updates also show the new pointer as the result word
				IPA_OP_DBL_INC: begin
					ptr[bk][a] = va + 32'h1;
					x_data = ptr[bk][a];
				end
				IPA_OP_DBL_DEC: begin
					ptr[bk][a] = va - 32'h1;
					x_data = ptr[bk][a];
				end
				IPA_OP_DBL_ADD: begin
					ptr[bk][a] = va + opd;
					x_data = ptr[bk][a];
				end
				IPA_OP_DBL_SUB: begin
					ptr[bk][a] = va - opd;
					x_data = ptr[bk][a];
				end
				IPA_OP_ADDR_IMPORT: begin
					ptr[bk][a] = opd + `IPA_CONV_DELTA;
					x_data = ptr[bk][a];
				end
				IPA_OP_NONE: x_data = va; // idle op still shows pointer a
				IPA_OP_ADDR_EXPORT: x_data = va - `IPA_CONV_DELTA;
				IPA_OP_RECORD_NUMBER: x_data = va;
				IPA_OP_INDIRECT: begin
					x_data = va;
					x_ea = va;
					if (md == IPA_AM_CONST) x_ea = va + sext(c);
					if (md == IPA_AM_DROFF) x_ea = va + sext(off[bk][o]);
					if (md == IPA_AM_INC1 || md == IPA_AM_INC2) x_data = va + st;
					if (md == IPA_AM_DEC1 || md == IPA_AM_DEC2) x_data = va - st;
					if (md == IPA_AM_DEC1 || md == IPA_AM_DEC2) x_ea = x_data;
					ptr[bk][a] = x_data;
				end
				IPA_OP_WORD_TRANSFER: begin
					x_data = {16'h0, w};
					{x_eq, x_lt, x_gt} = {w == 16'h0, 2'b00};
				end
				IPA_OP_RANGE_MIN: begin
					if (first || w < run_min[15:0]) begin
						run_min = {16'h0, w};
						ptr[bk][0] = opd;
					end
					x_data = run_min;
					{x_eq, x_lt, x_gt} = {run_min == 32'h0, 2'b00};
				end
				IPA_OP_OFFSET_LOAD: begin
					off[bk][o] = w;
					x_data = {16'h0, w};
				end
				default: ;
			endcase
		end
		@(negedge clk_in);
		check({31'h0, done_out}, {31'h0, ok});
		check({31'h0, err_out}, {31'h0, !ok});
		check(data_out, x_data);
		check(ea_out, x_ea);
		check({29'h0, eq_flag_out, lt_flag_out, gt_flag_out}, {29'h0, x_eq, x_lt, x_gt});
		check({31'h0, register_sharing_status_bit_out}, {31'h0, x_share});
	endtask

	// random op; range words kept below 8000 so signedness of the minimum cannot matter
	task automatic rnd_op();
		ipa_op_t op;
		logic [15:0] w;
		op = ops[$urandom_range(17)];
		w = ($urandom_range(3) == 0) ? 16'h0 : 16'($urandom);
		if (op == IPA_OP_RANGE_MIN) w = w & 16'h7fff;
		do_op(op, $urandom_range(7) == 0, 4'($urandom), 4'($urandom), $urandom,
			2'($urandom), modes[$urandom_range(6)], 16'($urandom), w, 4'($urandom),
			$urandom_range(3) == 0);
	endtask

	// read every pointer of every bank back through the record number op
	task automatic read_all();
		for (int t = 0; t < 4; t++) begin
			for (int i = 0; i < 16; i++) begin
				do_op(IPA_OP_RECORD_NUMBER, 1'b1, 4'(i), 4'h0, 32'h0, 2'(t));
			end
		end
	endtask

	// main sequence
	initial begin
		{errors, total_checks, cycles} = '0;
		{sys_rst_in, share_mode_in, op_valid_in, direct_ptr_in, range_first_in} = 5'b10000;
		{task_in, ptr_sel_in, ptr_sel2_in, off_sel_in} = '0;
		{const_off_in, word_src_in, operand_in} = '0;
		op_in = IPA_OP_NONE;
		mode_in = IPA_AM_PLAIN;
		void'($urandom(32'h1fa7));
		rst(1'b0);
		read_all();
		// wrap corners of 32-bit pointers, then pointer f and offset register 3 loaded
		do_op(IPA_OP_ADDR_LOAD, 1'b1, 4'h5, 4'h0, 32'hffffffff);
		do_op(IPA_OP_DBL_INC, 1'b1, 4'h5);
		do_op(IPA_OP_DBL_DEC, 1'b1, 4'h5);
		do_op(IPA_OP_INDIRECT, 1'b0, 4'h5, 4'h0, 32'h0, 2'h0, IPA_AM_INC2);
		do_op(IPA_OP_INDIRECT, 1'b0, 4'h5, 4'h0, 32'h0, 2'h0, IPA_AM_DEC2);
		do_op(IPA_OP_PV_ADDR_LOAD, 1'b1, 4'hf, 4'h0, 32'h12340007);
		do_op(IPA_OP_OFFSET_LOAD, 1'b0, 4'h0, 4'h0, 32'h0, 2'h0, IPA_AM_PLAIN, 16'h0, 16'hfffe,
			4'h3);
		// every addressing mode with a negative offset
		for (int i = 0; i < 7; i++) begin
			do_op(IPA_OP_INDIRECT, 1'b0, 4'hf, 4'h0, 32'h0, 2'h0, modes[i], 16'h8000, 16'h0,
				4'h3);
		end
		// every op named as a direct operand
		for (int i = 0; i < 18; i++) do_op(ops[i], 1'b1, 4'h5, 4'hf, 32'h00a0);
		do_op(IPA_OP_WORD_TRANSFER, 1'b0, 4'h0);
		do_op(IPA_OP_WORD_TRANSFER, 1'b0, 4'h0, 4'h0, 32'h0, 2'h0, IPA_AM_PLAIN, 16'h0, 16'h5);
		do_op(IPA_OP_RANGE_MIN, 1'b0, 4'h0, 4'h0, 32'h100, 2'h0, IPA_AM_PLAIN, 16'h0, 16'h7,
			4'h0, 1'b1);
		do_op(IPA_OP_RANGE_MIN, 1'b0, 4'h0, 4'h0, 32'h101);
		do_op(IPA_OP_RANGE_MIN, 1'b0, 4'h0, 4'h0, 32'h102, 2'h0, IPA_AM_PLAIN, 16'h0, 16'h3);
		do_op(IPA_OP_DBL_COMPARE, 1'b1, 4'h5, 4'h5);
		do_op(IPA_OP_DBL_SWAP, 1'b1, 4'h5, 4'h0);
		// banks apart per task
		do_op(IPA_OP_ADDR_LOAD, 1'b1, 4'h1, 4'h0, 32'haaaa, 2'h1);
		do_op(IPA_OP_RECORD_NUMBER, 1'b1, 4'h1, 4'h0, 32'h0, 2'h2);
		repeat (700) rnd_op();
		read_all();
		// reset in mid-run, now with one shared bank
		rst(1'b1);
		do_op(IPA_OP_ADDR_LOAD, 1'b1, 4'h1, 4'h0, 32'h5555, 2'h1);
		do_op(IPA_OP_RECORD_NUMBER, 1'b1, 4'h1, 4'h0, 32'h0, 2'h3);
		repeat (300) rnd_op();
		read_all();
		stop_test();
	end
endmodule
